//--- rtl/spfs_regs.vh
// Register indices, field positions, reset values and timing counts
// for the soft pin frequency scaling register bank.
// Assumes AHB-Lite byte address = 4 x register index.
`ifndef SPFS_REGS_VH
`define SPFS_REGS_VH

// Register indices; byte address is four times the index
`define SPFS_IDX_SYSPLL 12'hC02
`define SPFS_IDX_SEC2EN 12'hC03
`define SPFS_IDX_REFSCALE 12'hC04
`define SPFS_IDX_OUTSCALE 12'hC05
`define SPFS_IDX_TRANSFER 12'hC07

// Field positions
`define SPFS_SYSPLL_LSB 0
`define SPFS_SEC2EN_BIT 0
`define SPFS_REF1_LSB 0
`define SPFS_REF2_LSB 2
`define SPFS_CH0_LSB 0
`define SPFS_CH1_LSB 2
`define SPFS_TRANSFER_BIT 0

// Reset values
`define SPFS_RST_SYSPLL 2'h0
`define SPFS_RST_SEC2EN 1'h0
`define SPFS_RST_SCALE 4'h0

// System PLL reference settings per code
`define SPFS_FBDIV_C0 6'h10
`define SPFS_FBDIV_C1 6'h08
`define SPFS_FBDIV_C2 6'h20
`define SPFS_FBDIV_C3 6'h10

// Scale divide ratios per code
`define SPFS_DIV_C0 5'h01
`define SPFS_DIV_C1 5'h04
`define SPFS_DIV_C2 5'h08
`define SPFS_DIV_C3 5'h10

// ROM download duration in clock cycles
`define SPFS_LOAD_CYCLES 8

`endif

//--- rtl/spfs_scale_decode.v
// Decoder from a two-bit scale code to its divide ratio.
// Assumes the code comes from a flip-flop.
`timescale 1ns/10ps
`default_nettype none
`include "spfs_regs.vh"

module spfs_scale_decode (
	input wire [1:0] code,
	output reg [4:0] divide
);

	always @* begin
		case (code)
			2'h0: divide = `SPFS_DIV_C0;
			2'h1: divide = `SPFS_DIV_C1;
			2'h2: divide = `SPFS_DIV_C2;
			2'h3: divide = `SPFS_DIV_C3;
			default: divide = `SPFS_DIV_C0;
		endcase
	end

endmodule // spfs_scale_decode
`default_nettype wire

//--- rtl/spfs_soft_pin_regs.v
// Soft pin frequency scaling register bank with AHB-Lite slave port.
// Assumes one 20 MHz clock, asynchronous active-low reset, single word transfers.
//
// Function
// - Ref codes 01,10,11: 49.152 XTAL x2 N8; 24.576 XO N32; 49.152 XO N16.
// - Ref code 00: 24.576 MHz crystal, doubler on, feedback divide 16.
// - Section-two enable bit 0 applies the section-two scale settings.
// - Second reference input scale [3:2] divides by 1,4,8,16; default 1.
// - First reference input scale [1:0] divides by 1,4,8,16; default 1.
// - Channel-one output scale [3:2] divides by 1,4,8,16; default 1.
// - Channel-zero output scale [1:0] divides by 1,4,8,16; default 1.
`timescale 1ns/10ps
`default_nettype none
`include "spfs_regs.vh"

module spfs_soft_pin_regs #(
	parameter LOAD_CYCLES = `SPFS_LOAD_CYCLES
) (
	input wire clk,
	input wire rstn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	output reg sysPllRefXtal,
	output reg sysPllRef49M,
	output reg sysPllDoubler,
	output reg [5:0] sysPllFeedbackDiv,
	output reg [4:0] firstRefDivide,
	output reg [4:0] secondRefDivide,
	output reg [4:0] ch0Divide,
	output reg [4:0] ch1Divide,
	output reg loadDone
);

	localparam ST_IDLE = 1'b0;
	localparam ST_LOAD = 1'b1;

	// Settings held by software
	reg [1:0] sysPllRef_reg;
	reg sec2Enable_reg;
	reg [3:0] refScale_reg;
	reg [3:0] outScale_reg;
	reg transfer_reg;
	reg state_reg;
	reg [7:0] loadCnt_reg;

	// Data phase bookkeeping
	reg dataWrite_reg;
	reg dataRead_reg;
	reg [11:0] dataIdx_reg;
	reg dataMapped_reg;

	wire addrPhase;
	wire [11:0] addrIdx;
	wire addrMapped;
	wire wrSysPll;
	wire wrSec2;
	wire wrRefScale;
	wire wrOutScale;
	wire wrTransfer;
	wire loadFinish;
	wire [4:0] scaleDiv [0:3];
	wire [1:0] scaleCode [0:3];
	reg [31:0] readMux;
	reg sysXtalNext;
	reg sys49Next;
	reg sysDblNext;
	reg [5:0] sysFbNext;

	// Zero wait states: every access finishes in one data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	assign addrPhase = hsel && htrans[1] && hready;
	assign addrIdx = haddr[13:2];
	assign addrMapped = (haddr[31:14] == 18'h0_0000) && (haddr[1:0] == 2'h0) &&
		((addrIdx == `SPFS_IDX_SYSPLL) || (addrIdx == `SPFS_IDX_SEC2EN) ||
		(addrIdx == `SPFS_IDX_REFSCALE) || (addrIdx == `SPFS_IDX_OUTSCALE) ||
		(addrIdx == `SPFS_IDX_TRANSFER));

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dataWrite_reg <= 1'b0;
			dataRead_reg <= 1'b0;
			dataIdx_reg <= 12'h000;
			dataMapped_reg <= 1'b0;
		end else if (hready) begin
			dataWrite_reg <= addrPhase && hwrite;
			dataRead_reg <= addrPhase && !hwrite;
			dataIdx_reg <= addrIdx;
			dataMapped_reg <= addrPhase && addrMapped;
		end
	end

	assign wrSysPll = dataWrite_reg && dataMapped_reg && (dataIdx_reg == `SPFS_IDX_SYSPLL);
	assign wrSec2 = dataWrite_reg && dataMapped_reg && (dataIdx_reg == `SPFS_IDX_SEC2EN);
	assign wrRefScale = dataWrite_reg && dataMapped_reg && (dataIdx_reg == `SPFS_IDX_REFSCALE);
	assign wrOutScale = dataWrite_reg && dataMapped_reg && (dataIdx_reg == `SPFS_IDX_OUTSCALE);
	assign wrTransfer = dataWrite_reg && dataMapped_reg && (dataIdx_reg == `SPFS_IDX_TRANSFER);

	// Only the documented fields are stored; upper bits are dropped
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sysPllRef_reg <= `SPFS_RST_SYSPLL;
			sec2Enable_reg <= `SPFS_RST_SEC2EN;
			refScale_reg <= `SPFS_RST_SCALE;
			outScale_reg <= `SPFS_RST_SCALE;
		end else begin
			if (wrSysPll)
				sysPllRef_reg <= hwdata[1:0];
			if (wrSec2)
				sec2Enable_reg <= hwdata[`SPFS_SEC2EN_BIT];
			if (wrRefScale)
				refScale_reg <= hwdata[3:0];
			if (wrOutScale)
				outScale_reg <= hwdata[3:0];
		end
	end

	// Transfer bit: a new write of one wins over the self-clear
	assign loadFinish = (state_reg == ST_LOAD) &&
		(loadCnt_reg == LOAD_CYCLES[7:0] - 8'h01);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			transfer_reg <= 1'b0;
			state_reg <= ST_IDLE;
			loadCnt_reg <= 8'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					loadCnt_reg <= 8'h00;
					if (wrTransfer && hwdata[`SPFS_TRANSFER_BIT]) begin
						transfer_reg <= 1'b1;
						state_reg <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (wrTransfer && hwdata[`SPFS_TRANSFER_BIT]) begin
						// Restart so the latest settings are the ones taken
						loadCnt_reg <= 8'h00;
					end else if (loadFinish) begin
						transfer_reg <= 1'b0;
						state_reg <= ST_IDLE;
						loadCnt_reg <= 8'h00;
					end else begin
						loadCnt_reg <= loadCnt_reg + 8'h01;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					transfer_reg <= 1'b0;
					loadCnt_reg <= 8'h00;
				end
			endcase
		end
	end

	// System PLL reference translation
	always @* begin
		case (sysPllRef_reg)
			2'h0: begin
				sysXtalNext = 1'b1;
				sys49Next = 1'b0;
				sysDblNext = 1'b1;
				sysFbNext = `SPFS_FBDIV_C0;
			end
			2'h1: begin
				sysXtalNext = 1'b1;
				sys49Next = 1'b1;
				sysDblNext = 1'b1;
				sysFbNext = `SPFS_FBDIV_C1;
			end
			2'h2: begin
				sysXtalNext = 1'b0;
				sys49Next = 1'b0;
				sysDblNext = 1'b0;
				sysFbNext = `SPFS_FBDIV_C2;
			end
			2'h3: begin
				sysXtalNext = 1'b0;
				sys49Next = 1'b1;
				sysDblNext = 1'b0;
				sysFbNext = `SPFS_FBDIV_C3;
			end
			default: begin
				sysXtalNext = 1'b1;
				sys49Next = 1'b0;
				sysDblNext = 1'b1;
				sysFbNext = `SPFS_FBDIV_C0;
			end
		endcase
	end

	// Four scale fields share one decoder shape
	assign scaleCode[0] = refScale_reg[`SPFS_REF1_LSB +: 2];
	assign scaleCode[1] = refScale_reg[`SPFS_REF2_LSB +: 2];
	assign scaleCode[2] = outScale_reg[`SPFS_CH0_LSB +: 2];
	assign scaleCode[3] = outScale_reg[`SPFS_CH1_LSB +: 2];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : gScale
			spfs_scale_decode uDec (
				.code(scaleCode[gi]),
				.divide(scaleDiv[gi])
			);
		end
	endgenerate

	// Settings take effect only at the end of a download, never mid-edit
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sysPllRefXtal <= 1'b1;
			sysPllRef49M <= 1'b0;
			sysPllDoubler <= 1'b1;
			sysPllFeedbackDiv <= `SPFS_FBDIV_C0;
			firstRefDivide <= `SPFS_DIV_C0;
			secondRefDivide <= `SPFS_DIV_C0;
			ch0Divide <= `SPFS_DIV_C0;
			ch1Divide <= `SPFS_DIV_C0;
			loadDone <= 1'b0;
		end else begin
			loadDone <= 1'b0;
			if (loadFinish && !(wrTransfer && hwdata[`SPFS_TRANSFER_BIT])) begin
				loadDone <= 1'b1;
				sysPllRefXtal <= sysXtalNext;
				sysPllRef49M <= sys49Next;
				sysPllDoubler <= sysDblNext;
				sysPllFeedbackDiv <= sysFbNext;
				// Section two disabled leaves every path undivided
				firstRefDivide <= sec2Enable_reg ? scaleDiv[0] : `SPFS_DIV_C0;
				secondRefDivide <= sec2Enable_reg ? scaleDiv[1] : `SPFS_DIV_C0;
				ch0Divide <= sec2Enable_reg ? scaleDiv[2] : `SPFS_DIV_C0;
				ch1Divide <= sec2Enable_reg ? scaleDiv[3] : `SPFS_DIV_C0;
			end
		end
	end

	// Read mux; unmapped and reserved bits read zero
	always @* begin
		readMux = 32'h0000_0000;
		if (dataRead_reg && dataMapped_reg) begin
			case (dataIdx_reg)
				`SPFS_IDX_SYSPLL: readMux = {30'h0000_0000, sysPllRef_reg};
				`SPFS_IDX_SEC2EN: readMux = {31'h0000_0000, sec2Enable_reg};
				`SPFS_IDX_REFSCALE: readMux = {28'h000_0000, refScale_reg};
				`SPFS_IDX_OUTSCALE: readMux = {28'h000_0000, outScale_reg};
				`SPFS_IDX_TRANSFER: readMux = {31'h0000_0000, transfer_reg};
				default: readMux = 32'h0000_0000;
			endcase
		end
	end

	assign hrdata = readMux;

	// hsize is accepted but only whole words are supported
	wire unusedBits;
	assign unusedBits = ^hsize;

endmodule // spfs_soft_pin_regs
`default_nettype wire

//--- test/spfs_soft_pin_regs_checker.sv
// Port checker for the soft pin scaling register bank.
// Assumes one AHB-Lite slave, hready fed from hreadyout.
`timescale 1ns/10ps
`default_nettype none
module spfs_checker #(
	parameter LOAD_CYCLES = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic sysPllRefXtal,
	input wire logic sysPllRef49M,
	input wire logic sysPllDoubler,
	input wire logic [5:0] sysPllFeedbackDiv,
	input wire logic [4:0] firstRefDivide,
	input wire logic [4:0] secondRefDivide,
	input wire logic [4:0] ch0Divide,
	input wire logic [4:0] ch1Divide,
	input wire logic loadDone
);
	localparam int LoadLat = LOAD_CYCLES + 1;
	logic wrReg;
	logic rdReg;
	logic sec2Reg;
	logic [31:0] addrReg;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrReg <= 1'b0;
			rdReg <= 1'b0;
			sec2Reg <= 1'b0;
			addrReg <= 32'h0000_0000;
		end else begin
			wrReg <= hsel && htrans[1] && hready && hwrite;
			rdReg <= hsel && htrans[1] && hready && !hwrite;
			if (hready)
				addrReg <= haddr;
			// Mirror of the enable, so the apply-time value is known
			if (wrReg && addrReg == 32'h0000_300C)
				sec2Reg <= hwdata[0];
		end
	end
	sequence xferSet;
		wrReg && addrReg == 32'h0000_301C && hwdata[0];
	endsequence
	pll_code_map_a: assert property (
		sysPllDoubler == sysPllRefXtal && sysPllFeedbackDiv == (sysPllRefXtal ?
		(sysPllRef49M ? 6'h08 : 6'h10) : (sysPllRef49M ? 6'h10 : 6'h20)))
		else $error("pll settings inconsistent");
	ref_div_legal_a: assert property (
		firstRefDivide inside {5'h01, 5'h04, 5'h08, 5'h10} &&
		secondRefDivide inside {5'h01, 5'h04, 5'h08, 5'h10})
		else $error("bad reference divide");
	out_div_legal_a: assert property (
		ch0Divide inside {5'h01, 5'h04, 5'h08, 5'h10} &&
		ch1Divide inside {5'h01, 5'h04, 5'h08, 5'h10})
		else $error("bad output divide");
	sec2_off_unity_a: assert property (
		loadDone && !sec2Reg |-> {firstRefDivide, secondRefDivide, ch0Divide, ch1Divide}
		== {4{5'h01}})
		else $error("divides applied while disabled");
	hold_until_load_a: assert property (
		!loadDone |-> $stable({sysPllFeedbackDiv, sysPllRefXtal, sysPllRef49M,
		firstRefDivide, secondRefDivide, ch0Divide, ch1Divide}))
		else $error("outputs moved without a load");
	load_latency_a: assert property (xferSet |-> ##LoadLat loadDone)
		else $error("load did not finish in time");
	done_pulse_a: assert property (loadDone |=> !loadDone)
		else $error("load pulse too long");
	reserved_zero_a: assert property (rdReg |-> hrdata[31:4] == 28'h000_0000)
		else $error("reserved bits read nonzero");
endmodule // spfs_checker
bind spfs_soft_pin_regs spfs_checker #(.LOAD_CYCLES(LOAD_CYCLES)) chk (.clk, .rstn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .sysPllRefXtal,
	.sysPllRef49M, .sysPllDoubler, .sysPllFeedbackDiv, .firstRefDivide,
	.secondRefDivide, .ch0Divide, .ch1Divide, .loadDone);
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the soft pin scaling register bank.
// Assumes the bound checker; load time shortened to 2 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b1;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] lfsr = 32'h0000_18e3;
	logic [31:0] r;
	int failCount = 0;
	int numChecks = 0;
	wire logic hreadyout, hresp, sysPllRefXtal, sysPllRef49M, sysPllDoubler, loadDone;
	wire logic [31:0] hrdata;
	wire logic [5:0] sysPllFeedbackDiv;
	wire logic [4:0] firstRefDivide, secondRefDivide, ch0Divide, ch1Divide;
	always #25 clk = ~clk;
	spfs_soft_pin_regs #(.LOAD_CYCLES(2)) dut (.clk, .rstn, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .sysPllRefXtal, .sysPllRef49M, .sysPllDoubler, .sysPllFeedbackDiv,
		.firstRefDivide, .secondRefDivide, .ch0Divide, .ch1Divide, .loadDone);
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [4:0] divOf(input logic [1:0] c);
		return c == 2'h0 ? 5'h01 : 5'h02 << c;
	endfunction
	function automatic logic [8:0] pllOf(input logic [1:0] c);
		return {~c[1], c[0], ~c[1], c == 2'h1 ? 6'h08 : c == 2'h2 ? 6'h20 : 6'h10};
	endfunction
	task automatic summarize;
		if (failCount == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		numChecks++;
		if (g !== e) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait on ready or on the load pulse
	task automatic waitFor(input bit onDone);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((onDone ? loadDone : hreadyout) !== 1'b1 && n < 40);
		if (n >= 40) begin
			failCount++;
			summarize;
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		haddr <= {18'h0_0000, idx, 2'h0};
		hwrite <= w;
		htrans <= 2'h2;
		waitFor(0);
		htrans <= 2'h0;
		hwdata <= d;
		waitFor(0);
		q = hrdata;
	endtask
	// Random upper bits so reserved fields get written too
	task automatic load(input logic [1:0] code, input logic en);
		logic [31:0] rs;
		logic [31:0] os;
		lfsr = nxt(lfsr);
		rs = lfsr;
		lfsr = nxt(lfsr);
		os = lfsr;
		xfer(1'b1, 12'hC02, {os[31:2], code}, r);
		xfer(1'b1, 12'hC03, {rs[31:1], en}, r);
		xfer(1'b1, 12'hC04, rs, r);
		xfer(1'b1, 12'hC05, os, r);
		xfer(1'b0, 12'hC04, 32'h0000_0000, r);
		chk("refScale", {28'h000_0000, rs[3:0]}, r);
		xfer(1'b0, 12'hC03, 32'h0000_0000, r);
		chk("sec2Enable", {31'h0000_0000, en}, r);
		xfer(1'b1, 12'hC07, 32'h0000_0001, r);
		// Read back while the download still runs: the bit must stand
		xfer(1'b0, 12'hC07, 32'h0000_0000, r);
		chk("transferBusy", 32'h0000_0001, r);
		chk("hresp", 32'h0000_0000, hresp);
		waitFor(1);
		chk("pll", pllOf(code), {sysPllRefXtal, sysPllRef49M, sysPllDoubler,
			sysPllFeedbackDiv});
		chk("refDiv", en ? {divOf(rs[3:2]), divOf(rs[1:0])} : 10'h021,
			{secondRefDivide, firstRefDivide});
		chk("outDiv", en ? {divOf(os[3:2]), divOf(os[1:0])} : 10'h021,
			{ch1Divide, ch0Divide});
		xfer(1'b0, 12'hC07, 32'h0000_0000, r);
		chk("transfer", 32'h0000_0000, r);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("fbDivRst", 32'h0000_0010, sysPllFeedbackDiv);
		xfer(1'b0, 12'hC05, 32'h0000_0000, r);
		chk("outRst", 32'h0000_0000, r);
		for (int i = 0; i < 12; i++)
			load(i[1:0], !i[2]);
		xfer(1'b1, 12'hC06, 32'hFFFF_FFFF, r);
		xfer(1'b0, 12'hC06, 32'h0000_0000, r);
		chk("unmapped", 32'h0000_0000, r);
		summarize;
	end
endmodule // tb_top
`default_nettype wire
